//--- rtl/port_output_function_select.v
// Output function select for ports 7 to 15 with APB register access
//
// Operation
// R1 - A port 7 primary bit of zero keeps the pin in port role, one lets the secondary bit pick the output.
// R2 - Software clears the analog select bit whenever it sets port 7 secondary bits 0 to 4 or 6.
// R3 - Port 8 bits 0 to 2 follow the secondary register when primary is one, bit 2 picks compare 32 or CAN.
// R4 - Port 9 bits 1 and 7 follow the secondary register, zero gives the I2C clock, one the special serial tx.
// R5 - Analog select bit 7 routes port 10 pins 4 to 7 to port/key use at zero and to analog inputs at one.
// R6 - Software writes zero to reserved select bits.
`timescale 1ns/1ps
`include "pin_select_defs.vh"
module port_output_function_select (
    // APB
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Port 7 routing: 1 peripheral output, then which source
    output reg  [7:0]  p7_periph_out,
    output reg  [7:0]  p7_use_secondary,
    output reg  [7:0]  p7_use_analog_sel,
    // Port 8
    output reg  [2:0]  p8_periph_out,
    output reg         p8_can_transmit_output,
    output reg         p8_compare_output_32,
    output reg  [1:0]  p8_alt_sel,
    // Port 9
    output reg  [7:0]  p9_periph_out,
    output reg         p9_i2c_clock_ch3,
    output reg         p9_special_serial_tx_ch3,
    output reg         p9_i2c_clock_ch4,
    output reg         p9_special_serial_tx_ch4,
    output reg  [7:0]  p9_alt_sel,
    // Port 10
    output reg         p10_analog_inputs_4_to_7,
    // Ports 11 to 15
    output reg  [7:0]  p11_periph_out,
    output reg  [7:0]  p12_periph_out,
    output reg  [7:0]  p13_periph_out,
    output reg  [7:0]  p14_periph_out,
    output reg  [7:0]  p15_periph_out
);
    wire [7:0] port7_primary_select;
    wire [7:0] port7_secondary_select;
    wire [7:0] analog_peripheral_select;
    wire [7:0] port8_primary_select;
    wire [7:0] port8_secondary_select;
    wire [7:0] port9_primary_select;
    wire [7:0] port9_secondary_select;
    wire [7:0] port11_select;
    wire [7:0] port12_select;
    wire [7:0] port13_select;
    wire [7:0] port14_select;
    wire [7:0] port15_select;
    wire       setup;
    wire       wr_en;
    reg        hit;
    reg  [7:0] rd_byte;

    // Zero wait states: pready rises in the first access cycle
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready;

    always @* begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            `OFS_P7_PRI: rd_byte = port7_primary_select;
            `OFS_P7_SEC: rd_byte = port7_secondary_select;
            `OFS_APS:    rd_byte = analog_peripheral_select;
            `OFS_P8_PRI: rd_byte = port8_primary_select;
            `OFS_P8_SEC: rd_byte = port8_secondary_select;
            `OFS_P9_PRI: rd_byte = port9_primary_select;
            `OFS_P9_SEC: rd_byte = port9_secondary_select;
            `OFS_P11:    rd_byte = port11_select;
            `OFS_P12:    rd_byte = port12_select;
            `OFS_P13:    rd_byte = port13_select;
            `OFS_P14:    rd_byte = port14_select;
            `OFS_P15:    rd_byte = port15_select;
            default:     hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    sel_reg8 #(.MASK(8'hff)) u_p7p (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P7_PRI),
        .wdata   (pwdata[7:0]),
        .q       (port7_primary_select)
    );
    sel_reg8 #(.MASK(8'hff)) u_p7s (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P7_SEC),
        .wdata   (pwdata[7:0]),
        .q       (port7_secondary_select)
    );
    sel_reg8 #(.MASK(8'hff)) u_aps (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_APS),
        .wdata   (pwdata[7:0]),
        .q       (analog_peripheral_select)
    );
    // Reserved bits masked on write; software still owes zeros (see R6)
    sel_reg8 #(.MASK(`P8_MASK)) u_p8p (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P8_PRI),
        .wdata   (pwdata[7:0]),
        .q       (port8_primary_select)
    );
    sel_reg8 #(.MASK(`P8_MASK)) u_p8s (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P8_SEC),
        .wdata   (pwdata[7:0]),
        .q       (port8_secondary_select)
    );
    sel_reg8 #(.MASK(8'hff)) u_p9p (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P9_PRI),
        .wdata   (pwdata[7:0]),
        .q       (port9_primary_select)
    );
    sel_reg8 #(.MASK(8'hfe)) u_p9s (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P9_SEC),
        .wdata   (pwdata[7:0]),
        .q       (port9_secondary_select)
    );
    sel_reg8 #(.MASK(`P11_MASK)) u_p11 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P11),
        .wdata   (pwdata[7:0]),
        .q       (port11_select)
    );
    sel_reg8 #(.MASK(8'hff)) u_p12 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P12),
        .wdata   (pwdata[7:0]),
        .q       (port12_select)
    );
    sel_reg8 #(.MASK(8'hff)) u_p13 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P13),
        .wdata   (pwdata[7:0]),
        .q       (port13_select)
    );
    sel_reg8 #(.MASK(`P14_MASK)) u_p14 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P14),
        .wdata   (pwdata[7:0]),
        .q       (port14_select)
    );
    sel_reg8 #(.MASK(`P15_MASK)) u_p15 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_en && paddr == `OFS_P15),
        .wdata   (pwdata[7:0]),
        .q       (port15_select)
    );

    // Routing outputs registered, one cycle behind the register write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p7_periph_out            <= 8'h00;
            p7_use_secondary         <= 8'h00;
            p7_use_analog_sel        <= 8'h00;
            p8_periph_out            <= 3'h0;
            p8_can_transmit_output   <= 1'b0;
            p8_compare_output_32     <= 1'b0;
            p8_alt_sel               <= 2'h0;
            p9_periph_out            <= 8'h00;
            p9_i2c_clock_ch3         <= 1'b0;
            p9_special_serial_tx_ch3 <= 1'b0;
            p9_i2c_clock_ch4         <= 1'b0;
            p9_special_serial_tx_ch4 <= 1'b0;
            p9_alt_sel               <= 8'h00;
            p10_analog_inputs_4_to_7 <= 1'b0;
            p11_periph_out           <= 8'h00;
            p12_periph_out           <= 8'h00;
            p13_periph_out           <= 8'h00;
            p14_periph_out           <= 8'h00;
            p15_periph_out           <= 8'h00;
        end else begin
            // Secondary choice only matters where primary selects output, except p9_alt_sel, which copies the whole port 9 secondary register
            p7_periph_out     <= port7_primary_select;                             // see R1
            p7_use_secondary  <= port7_primary_select & port7_secondary_select;    // see R1
            p7_use_analog_sel <= port7_primary_select & ~port7_secondary_select;   // see R1
            p8_periph_out     <= port8_primary_select[2:0];                        // see R3
            p8_alt_sel        <= port8_primary_select[1:0] & port8_secondary_select[1:0];
            p8_can_transmit_output <= port8_primary_select[`P8_CAN_BIT]
                                    & port8_secondary_select[`P8_CAN_BIT];          // see R3
            p8_compare_output_32   <= port8_primary_select[`P8_CAN_BIT]
                                    & ~port8_secondary_select[`P8_CAN_BIT];         // see R3
            p9_periph_out <= port9_primary_select;
            p9_alt_sel    <= port9_secondary_select;
            p9_i2c_clock_ch3 <= port9_primary_select[`P9_CH3_BIT]
                              & ~port9_secondary_select[`P9_CH3_BIT];               // see R4
            p9_special_serial_tx_ch3 <= port9_primary_select[`P9_CH3_BIT]
                                      & port9_secondary_select[`P9_CH3_BIT];        // see R4
            p9_i2c_clock_ch4 <= port9_primary_select[`P9_CH4_BIT]
                              & ~port9_secondary_select[`P9_CH4_BIT];               // see R4
            p9_special_serial_tx_ch4 <= port9_primary_select[`P9_CH4_BIT]
                                      & port9_secondary_select[`P9_CH4_BIT];        // see R4
            p10_analog_inputs_4_to_7 <= analog_peripheral_select[`APS_ANALOG_BIT]; // see R5
            p11_periph_out <= port11_select;
            p12_periph_out <= port12_select;
            p13_periph_out <= port13_select;
            p14_periph_out <= port14_select;
            p15_periph_out <= port15_select;
        end
    end
endmodule

//--- shared/pin_select_defs.vh
// Offsets, reset values and field positions of the output select registers
`ifndef PIN_SELECT_DEFS_VH
`define PIN_SELECT_DEFS_VH
`define OFS_P7_SEC      12'h000
`define OFS_APS         12'h004
`define OFS_P8_PRI      12'h008
`define OFS_P8_SEC      12'h00c
`define OFS_P9_PRI      12'h010
`define OFS_P9_SEC      12'h014
`define OFS_P11         12'h018
`define OFS_P12         12'h01c
`define OFS_P13         12'h020
`define OFS_P14         12'h024
`define OFS_P15         12'h028
`define OFS_P7_PRI      12'h02c
`define SEL_RESET       8'h00
`define APS_ANALOG_BIT  7
`define P8_CAN_BIT      2
`define P9_CH3_BIT      1
`define P9_CH4_BIT      7
`define P8_MASK         8'h07
`define P11_MASK        8'h0f
`define P14_MASK        8'h0f
`define P15_MASK        8'h33
`endif

//--- rtl/sel_reg8.v
// One 8-bit select register with write mask
`timescale 1ns/1ps
module sel_reg8 #(
    parameter [7:0] MASK = 8'hff
) (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Write port
    input  wire       wr,
    input  wire [7:0] wdata,
    // Stored value
    output reg  [7:0] q
);
    // Reserved bits kept at zero so a stray one cannot route anything
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= 8'h00;
        end else if (wr) begin
            q <= wdata & MASK;
        end
    end
endmodule

//--- bench/pin_select_props.sv
// Bus and routing checks for the output select block
`timescale 1ns/1ps
module pin_select_props (
    input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [7:0]  p7_periph_out, p7_use_secondary, p7_use_analog_sel, p9_periph_out, p9_alt_sel,
    input wire [2:0]  p8_periph_out,
    input wire        p8_can_transmit_output, p8_compare_output_32,
    input wire        p9_i2c_clock_ch3, p9_special_serial_tx_ch3, p10_analog_inputs_4_to_7
);
    logic last_an;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bit of the last accepted analog select write
    always @(posedge pclk or negedge presetn)
        if (!presetn) last_an <= 1'b0;
        else if (pready && pwrite && paddr == 12'h004) last_an <= pwdata[7];
    a_ready_after_setup: assert property (psel && !penable |=> pready && penable) else $error("no answer");
    a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h02c || paddr[1:0] != 2'b00))
        else $error("bad error");
    a_p7_split: assert property ((p7_use_secondary | p7_use_analog_sel) == p7_periph_out
        && (p7_use_secondary & p7_use_analog_sel) == 8'h00) else $error("port 7 split");
    a_p8_one_source: assert property ((p8_can_transmit_output | p8_compare_output_32) == p8_periph_out[2]
        && !(p8_can_transmit_output && p8_compare_output_32)) else $error("port 8 source");
    a_p9_ch3_pick: assert property ({p9_i2c_clock_ch3, p9_special_serial_tx_ch3} ==
        {p9_periph_out[1] & ~p9_alt_sel[1], p9_periph_out[1] & p9_alt_sel[1]}) else $error("port 9 pick");
    a_p10_follow: assert property (pready && pwrite && paddr == 12'h004
        |=> ##1 p10_analog_inputs_4_to_7 == last_an) else $error("port 10 route");
endmodule
bind port_output_function_select pin_select_props chk (.*);

//--- bench/periph_pin_model.sv
// Port 8 pin 2 driven by the compare or CAN output
`timescale 1ns/1ps
module periph_pin_model (
    input wire  sel, can_on, cmp_on, can_src, cmp_src,
    output wire pin
);
    // Released pin floats to its pull-up level
    assign pin = !sel ? 1'b1 : can_on ? can_src : cmp_on ? cmp_src : 1'bx;
endmodule

//--- bench/test_port_output_function_select.sv
// Self-checking bench for the output select block
`timescale 1ns/1ps
module test_port_output_function_select;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, can_src, cmp_src, pin_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] p7_periph_out, p7_use_secondary, p7_use_analog_sel, p9_periph_out, p9_alt_sel;
    logic [7:0] p11_periph_out, p12_periph_out, p13_periph_out, p14_periph_out, p15_periph_out;
    logic [2:0] p8_periph_out;
    logic [1:0] p8_alt_sel;
    logic p8_can_transmit_output, p8_compare_output_32, p9_i2c_clock_ch3, p9_special_serial_tx_ch3;
    logic p9_i2c_clock_ch4, p9_special_serial_tx_ch4, p10_analog_inputs_4_to_7;
    logic [32:0] expq[$];
    logic [7:0] shadow [0:12];
    logic [7:0] mask [0:12] = '{8'hff, 8'hff, 8'h07, 8'h07, 8'hff, 8'hfe, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'h33, 8'hff, 8'h00};
    logic [7:0] d;
    int mismatches = 0, checks = 0, seed = 32'h969e, i, n;
    port_output_function_select dut (.*);
    periph_pin_model pin8 (.sel(p8_periph_out[2]), .can_on(p8_can_transmit_output),
        .cmp_on(p8_compare_output_32), .can_src(can_src), .cmp_src(cmp_src), .pin(pin_out));
    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v);
        int w;
        if (wr) shadow[a[5:2]] = v & mask[a[5:2]];
        else expq.push_back({a[5:2] == 4'd12, 24'h0, shadow[a[5:2]]});
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'($random(seed)), v};
        @(posedge pclk) penable <= 1;
        w = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++w < 20);
        if (w >= 20) mismatches++;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // Reads are judged here, in the cycle the answer stands
    always @(posedge pclk) if (pready === 1'b1 && pwrite === 1'b0) chk({pslverr, prdata}, expq.pop_front());
    task automatic check_outputs();
        can_src <= 1'($random(seed));
        cmp_src <= 1'($random(seed));
        repeat (2) @(posedge pclk);
        chk({p7_use_secondary, p7_use_analog_sel, p7_periph_out},
            {shadow[11] & shadow[0], shadow[11] & ~shadow[0], shadow[11]});
        chk({p8_periph_out, p8_can_transmit_output, p8_compare_output_32, p8_alt_sel}, {shadow[2][2:0],
            shadow[2][2] & shadow[3][2], shadow[2][2] & ~shadow[3][2], shadow[2][1:0] & shadow[3][1:0]});
        chk(pin_out, !shadow[2][2] ? 1'b1 : shadow[3][2] ? can_src : cmp_src);
        chk({p9_periph_out, p9_alt_sel, p9_i2c_clock_ch3, p9_special_serial_tx_ch3, p9_i2c_clock_ch4,
            p9_special_serial_tx_ch4}, {shadow[4], shadow[5], shadow[4][1] & ~shadow[5][1],
            shadow[4][1] & shadow[5][1], shadow[4][7] & ~shadow[5][7], shadow[4][7] & shadow[5][7]});
        chk(p10_analog_inputs_4_to_7, shadow[1][7]);
        chk({p11_periph_out, p12_periph_out, p13_periph_out, p14_periph_out, p15_periph_out},
            {shadow[6], shadow[7], shadow[8], shadow[9], shadow[10]});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        finish_test();
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; can_src = 0; cmp_src = 1;
        foreach (shadow[k]) shadow[k] = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 13; i++) apb(0, 12'(i * 4), 8'h00);
        check_outputs();
        $display("reset values done");
        for (n = 0; n < 60; n++) begin
            i = {$random(seed)} % 13;
            d = 8'($random(seed));
            // Secondary port 7 bits 0 to 4 and 6 and their analog select bits never both set
            if (i < 2) d &= ~(shadow[1 - i] & 8'h5f);
            // Reserved select bits always written as zero
            d &= mask[i];
            apb(1, 12'(i * 4), d);
            if (n % 3 == 2) check_outputs();
            apb(0, 12'(i * 4), 8'h00);
        end
        $display("random routing done");
        finish_test();
    end
endmodule
